/* File: src/nand_host_pkg.sv */
// Purpose: shared constants, opcodes and bus-cycle decoding for the NAND read-side host controller
// Assumes: 10 MHz ref_clk, 8-bit multiplexed NAND bus, one chip select
// Notes: the busy and read-gap waits are whole clock periods derived from the ns figures below; strobe phases are one period each
//
// Overview of operation
// - page read address goes out as four bytes; column low, then column high with upper nibble low
// - data output: latch enables low, chip select low, write strobe high, read strobe toggles
// - host never issues a code outside the defined set; bad requests are refused
// - random column output is requested only inside the currently loaded page
// - page read is 00h, four address cycles, then 30h which starts the array transfer
// - completion may also be checked by issuing the 70h status command
// - after a status read the host writes 00h again before reading page data
// - random column output is 05h, two column cycles, E0h, then sequential reads
// - identification is 90h plus address 00h, returning five bytes on read strobes
package nand_host_pkg;

    // clock and pin timing
    localparam int CLK_PERIOD_NS         = 100;
    localparam int TWB_NS                = 100;    // strobe to busy valid, a least wait
    localparam int TWHR_NS               = 60;     // write strobe high to first read
    localparam int ARRAY_TRANSFER_TIME_NS = 25000; // worst page load, for reference
    localparam int TWB_CYCLES_I  = (TWB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TWHR_CYCLES_I = (TWHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] TWB_CYCLES  = 4'(TWB_CYCLES_I < 1 ? 1 : TWB_CYCLES_I);
    localparam logic [3:0] TWHR_CYCLES = 4'(TWHR_CYCLES_I < 1 ? 1 : TWHR_CYCLES_I);

    // geometry
    localparam logic [12:0] PAGE_BYTES = 13'h0840; // 2048 data + 64 spare
    localparam int          DATA_W     = 8;
    localparam int          FIFO_DEPTH = 4;

    // request opcodes on the user port
    localparam logic [2:0] OP_PAGE_READ = 3'h0;
    localparam logic [2:0] OP_RAND_OUT  = 3'h1;
    localparam logic [2:0] OP_IDENTIFICATION_CMD   = 3'h2;
    localparam logic [2:0] OP_PARAM     = 3'h3;
    localparam logic [2:0] OP_STATUS    = 3'h4;
    localparam logic [2:0] OP_RESET     = 3'h5;
    localparam logic [2:0] OP_READ_MODE = 3'h6;

    // bus command codes
    localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
    localparam logic [7:0] CMD_READ_START  = 8'h30;
    localparam logic [7:0] CMD_COL_SETUP   = 8'h05;
    localparam logic [7:0] CMD_COL_START   = 8'hE0;
    localparam logic [7:0] IDENTIFICATION_CMD = 8'h90;
    localparam logic [7:0] CMD_PARAM_PAGE  = 8'hEC;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_RESET       = 8'hFF;
    localparam logic [7:0] PARAM_ADDR      = 8'h00;

    typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_CMD2, ST_WAIT_WB, ST_WAIT_RDY, ST_GAP, ST_READ,
                  ST_END} state_t;

    // opcode is one of the defined operations
    function automatic logic op_defined(input logic [2:0] op);
        return op <= OP_READ_MODE;
    endfunction

    function automatic logic [7:0] first_code(input logic [2:0] op);
        case (op)
            OP_RAND_OUT: return CMD_COL_SETUP;
            OP_IDENTIFICATION_CMD:  return IDENTIFICATION_CMD;
            OP_PARAM:    return CMD_PARAM_PAGE;
            OP_STATUS:   return CMD_STATUS;
            OP_RESET:    return CMD_RESET;
            default:     return CMD_READ_SETUP;
        endcase
    endfunction

    function automatic logic [2:0] addr_count(input logic [2:0] op);
        case (op)
            OP_PAGE_READ: return 3'h4;
            OP_RAND_OUT:  return 3'h2;
            OP_IDENTIFICATION_CMD:   return 3'h1;
            OP_PARAM:     return 3'h1;
            default:      return 3'h0;
        endcase
    endfunction

    function automatic logic has_second(input logic [2:0] op);
        return op == OP_PAGE_READ || op == OP_RAND_OUT;
    endfunction

    // operations that start an array transfer or a reset and hold the device busy
    function automatic logic waits_busy(input logic [2:0] op);
        return op == OP_PAGE_READ || op == OP_PARAM || op == OP_RESET;
    endfunction

endpackage

/* File: src/read_fifo.sv */
// Purpose: small first-in first-out buffer between the NAND read path and the user stream
// Assumes: DEPTH is a power of two
// Notes: no bypass; a byte pushed is visible on the next cycle
`timescale 1ns/10ps
module read_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // honest flags from the occupancy count
    assign in_ready  = count_reg != FULL_COUNT;
    assign out_valid = count_reg != '0;
    assign out_data  = mem[rd_ptr_reg];

    // storage carries no reset, only the pointers and the count do
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointers wrap naturally because depth is a power of two
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule // read_fifo

/* File: src/nand_read_host.sv */
// Purpose: host controller that drives a NAND flash read side over its pins
// Assumes: pin inputs synchronous to ref_clk; one device on the bus
// Notes: read bytes pass through a 4-deep buffer; the host stalls its read strobes when it is full
`timescale 1ns/10ps
module nand_read_host (
    // clock and reset
    input  wire logic                               ref_clk,
    input  wire logic                               reset,
    // user request port
    input  wire logic                               req_valid,
    output logic                                    req_ready,
    input  wire logic [2:0]                         req_op,
    input  wire logic [11:0]                        req_col,
    input  wire logic [15:0]                        req_row,
    input  wire logic [11:0]                        req_count,
    output logic                                    req_done,
    output logic                                    req_err,
    // read data stream
    output logic                                    rd_valid,
    input  wire logic                               rd_ready,
    output logic      [nand_host_pkg::DATA_W-1:0]   rd_data,
    // NAND control pins
    output logic                                    ce_n,
    output logic                                    cle,
    output logic                                    ale,
    output logic                                    we_n,
    output logic                                    read_strobe_n,
    output logic                                    wp_n,
    input  wire logic                               ready_busy_n,
    // NAND data pins
    input  wire logic [7:0]                         io_in,
    output logic      [7:0]                         io_out,
    output logic                                    io_oe_n
);
    import nand_host_pkg::*;

    // every check below runs on ref_clk and sleeps through reset
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    state_t      state_reg, state_next;
    logic [1:0]  ph_reg, ph_next;
    logic [2:0]  op_reg, op_next;
    logic [11:0] col_reg, col_next;
    logic [15:0] row_reg, row_next;
    logic [11:0] count_reg, count_next;
    logic [1:0]  idx_reg, idx_next;
    logic [3:0]  wait_reg, wait_next;
    logic [7:0]  byte_reg, byte_next;
    logic        loaded_reg, loaded_next;
    logic        dirty_reg, dirty_next;
    logic        err_reg, err_next;
    logic        fifo_in_ready;

    // address byte for a given cycle index of the current operation
    function automatic logic [7:0] addr_byte(input logic [2:0] op, input logic [1:0] idx,
                                             input logic [11:0] col, input logic [15:0] row);
        if (op == OP_IDENTIFICATION_CMD) return col[7:0];               // 00h or 20h
        if (op == OP_PARAM) return PARAM_ADDR;
        case (idx)
            2'd0:    return col[7:0];
            2'd1:    return {4'h0, col[11:8]};               // upper lines held low
            2'd2:    return row[7:0];
            default: return row[15:8];
        endcase
    endfunction

    // request screening: refuse undefined codes and out-of-page column jumps
    wire [12:0] col_end    = 13'(req_col) + 13'(req_count);
    wire        bad_op     = !op_defined(req_op);
    wire        bad_col    = req_op == OP_RAND_OUT &&
                             (!loaded_reg || dirty_reg || col_end > PAGE_BYTES);
    wire        bad_mode   = req_op == OP_READ_MODE && !loaded_reg;
    wire        accept_ok  = !bad_op && !bad_col && !bad_mode;
    wire        take       = req_valid && req_ready;
    wire        in_write   = state_reg == ST_CMD || state_reg == ST_ADDR || state_reg == ST_CMD2;
    wire        wr_last    = ph_reg == 2'd2;
    wire        push       = state_reg == ST_READ && ph_reg == 2'd0;
    wire [2:0]  n_addr     = addr_count(op_reg);
    wire [2:0]  idx_plus   = 3'(idx_reg) + 3'd1;
    wire [7:0]  next_addr  = addr_byte(op_reg, idx_plus[1:0], col_reg, row_reg);
    wire        last_addr  = idx_plus >= n_addr;

    // pin decode: three-phase write cycle (setup, strobe low, hold), two-phase read
    assign req_ready     = state_reg == ST_IDLE;
    assign req_done      = state_reg == ST_END;
    assign req_err       = err_reg;
    assign ce_n          = state_reg == ST_IDLE || state_reg == ST_END;
    assign cle           = state_reg == ST_CMD || state_reg == ST_CMD2;
    assign ale           = state_reg == ST_ADDR;
    assign we_n          = !(in_write && ph_reg == 2'd1);
    assign read_strobe_n = !push;
    assign io_oe_n       = !in_write;
    assign io_out        = byte_reg;
    assign wp_n          = 1'b0;   // this host never programs or erases, so keep the array guarded

    // sequencer next-state logic
    always_comb begin
        state_next  = state_reg;
        ph_next     = ph_reg;
        op_next     = op_reg;
        col_next    = col_reg;
        row_next    = row_reg;
        count_next  = count_reg;
        idx_next    = idx_reg;
        wait_next   = wait_reg;
        byte_next   = byte_reg;
        loaded_next = loaded_reg;
        dirty_next  = dirty_reg;
        err_next    = take && !accept_ok;
        if (in_write) ph_next = wr_last ? 2'd0 : ph_reg + 2'd1;
        case (state_reg)
            ST_IDLE: begin
                if (take && accept_ok) begin
                    op_next    = req_op;
                    col_next   = req_col;
                    row_next   = req_row;
                    count_next = req_count;
                    ph_next    = 2'd0;
                    byte_next  = first_code(req_op);  // 00h sent even if preloaded
                    state_next = ST_CMD;
                end
            end
            ST_CMD: begin
                if (wr_last) begin
                    idx_next  = 2'd0;
                    byte_next = addr_byte(op_reg, 2'd0, col_reg, row_reg);
                    if (n_addr != 3'd0) state_next = ST_ADDR;
                    else if (waits_busy(op_reg)) state_next = ST_WAIT_WB;
                    else state_next = ST_GAP;
                    wait_next = waits_busy(op_reg) ? TWB_CYCLES : TWHR_CYCLES;
                end
            end
            ST_ADDR: begin
                if (wr_last) begin
                    idx_next  = idx_plus[1:0];
                    byte_next = next_addr;
                    if (!last_addr) begin
                        state_next = ST_ADDR;
                    end else if (has_second(op_reg)) begin
                        byte_next  = op_reg == OP_PAGE_READ ? CMD_READ_START : CMD_COL_START;
                        state_next = ST_CMD2;
                    end else begin
                        state_next = waits_busy(op_reg) ? ST_WAIT_WB : ST_GAP;
                        wait_next  = waits_busy(op_reg) ? TWB_CYCLES : TWHR_CYCLES;
                    end
                end
            end
            ST_CMD2: begin
                if (wr_last) begin
                    state_next = waits_busy(op_reg) ? ST_WAIT_WB : ST_GAP;
                    wait_next  = waits_busy(op_reg) ? TWB_CYCLES : TWHR_CYCLES;
                end
            end
            ST_WAIT_WB: begin
                wait_next = wait_reg - 4'd1;
                if (wait_reg == 4'd1) state_next = ST_WAIT_RDY;
            end
            ST_WAIT_RDY: begin
                // nothing is written while the device is busy
                if (ready_busy_n) begin
                    state_next = op_reg == OP_RESET ? ST_END : ST_GAP;
                    wait_next  = TWHR_CYCLES;
                end
            end
            ST_GAP: begin
                wait_next = wait_reg - 4'd1;
                if (wait_reg <= 4'd1) begin
                    state_next = ST_READ;
                    ph_next    = 2'd1;
                end
            end
            ST_READ: begin
                if (ph_reg == 2'd0) begin
                    count_next = count_reg - 12'd1;
                    ph_next    = 2'd1;
                end else if (count_reg == 12'd0) begin
                    state_next = ST_END;
                end else if (fifo_in_ready) begin
                    ph_next = 2'd0;          // strobe only when the buffer has room
                end
            end
            default: begin
                // end of operation: track what the data register now holds
                state_next = ST_IDLE;
                case (op_reg)
                    OP_PAGE_READ, OP_PARAM: begin
                        loaded_next = 1'b1;
                        dirty_next  = 1'b0;
                    end
                    OP_IDENTIFICATION_CMD, OP_RESET: loaded_next = 1'b0;
                    OP_STATUS:    dirty_next = 1'b1;
                    OP_READ_MODE: dirty_next = 1'b0;
                    default:      dirty_next = dirty_reg;
                endcase
            end
        endcase
    end

    // state registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg  <= ST_IDLE;
            ph_reg     <= 2'd0;
            op_reg     <= OP_PAGE_READ;
            col_reg    <= 12'h000;
            row_reg    <= 16'h0000;
            count_reg  <= 12'h000;
            idx_reg    <= 2'd0;
            wait_reg   <= 4'h0;
            byte_reg   <= 8'h00;
            loaded_reg <= 1'b0;
            dirty_reg  <= 1'b0;
            err_reg    <= 1'b0;
        end else begin
            state_reg  <= state_next;
            ph_reg     <= ph_next;
            op_reg     <= op_next;
            col_reg    <= col_next;
            row_reg    <= row_next;
            count_reg  <= count_next;
            idx_reg    <= idx_next;
            wait_reg   <= wait_next;
            byte_reg   <= byte_next;
            loaded_reg <= loaded_next;
            dirty_reg  <= dirty_next;
            err_reg    <= err_next;
        end
    end

    // read bytes are sampled at the end of the strobe-low cycle
    read_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (io_in),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // address strobes seen in this operation, for checking only
    logic [2:0] ale_seen_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) ale_seen_reg <= 3'd0;
        else if (state_reg == ST_IDLE) ale_seen_reg <= 3'd0;
        else if (ale && ph_reg == 2'd1) ale_seen_reg <= ale_seen_reg + 3'd1;
    end

    sequence we_low_s;
        !we_n && !io_oe_n;
    endsequence
    sequence we_hold_s;
        we_n && !io_oe_n && $stable(io_out) && $stable(cle) && $stable(ale);
    endsequence

    idle_chip_off_a: assert property (state_reg == ST_IDLE |-> ce_n && io_oe_n)
        else $error("chip select or data drive active while idle");
    read_pins_a: assert property (!read_strobe_n |-> !cle && !ale && !ce_n && we_n && io_oe_n)
        else $error("read strobe low with wrong control pins");
    write_pulse_a: assert property ($fell(we_n) |-> we_low_s ##1 we_hold_s)
        else $error("write strobe pulse not one cycle with held data");
    addr_count_a: assert property (state_reg == ST_END |-> ale_seen_reg == addr_count(op_reg))
        else $error("address cycle count does not match operation");
    busy_quiet_a: assert property (state_reg == ST_WAIT_RDY && !ready_busy_n |=> we_n && io_oe_n)
        else $error("bus written while device busy");
    busy_release_a: assert property (state_reg == ST_WAIT_RDY && ready_busy_n && op_reg != OP_RESET
                                     |=> state_reg == ST_GAP)
        else $error("ready not followed to the read gap");
    bad_op_err_a: assert property (take && !op_defined(req_op) |=> req_err && state_reg == ST_IDLE)
        else $error("undefined opcode not refused");
    col_bound_a: assert property (take && req_op == OP_RAND_OUT && col_end > PAGE_BYTES
                                  |=> state_reg == ST_IDLE && req_err)
        else $error("out-of-page column jump accepted");
    status_reread_a: assert property (dirty_reg && take && req_op == OP_RAND_OUT |=> req_err)
        else $error("column jump accepted before read mode restored");
    strobe_count_a: assert property (push && count_reg == 12'd1 |=> ##1 state_reg == ST_END)
        else $error("read did not end after last byte");
    page_read_cmd_a: assert property (state_reg == ST_CMD2 && op_reg == OP_PAGE_READ
                                      |-> byte_reg == CMD_READ_START)
        else $error("page read second code wrong");
endmodule // nand_read_host

/* File: verif/flash_dev.sv */
// Purpose: behavioural flash device on the far side of nand_read_host
// Assumes: bytes latched on write strobe rise, data shown while read strobe low
// Notes: released bus shows the inverse of the last byte
`timescale 1ns/10ps
module flash_dev #(parameter int BUSY_NS = 2000) (
    // control pins from host
    input  wire logic       ce_n, cle, ale, we_n, read_strobe_n, io_oe_n,
    input  wire logic [7:0] io_out,
    // device outputs
    output logic [7:0]      io_in,
    output logic            ready_busy_n = 1'b1,
    output logic            bad = 1'b0
);
    logic [7:0] cmd_reg = 8'h00, dout = 8'h00;
    logic [11:0] col = 12'h000, ptr = 12'h000;
    logic [15:0] row = 16'h0000;
    int mode = 0, na = 0;
    function automatic logic [7:0] pg(logic [15:0] r, logic [11:0] c);
        return r[7:0] ^ r[15:8] ^ c[7:0] ^ {4'h5, c[11:8]};
    endfunction
    // busy for a fixed load time
    task automatic go_busy;
        fork begin ready_busy_n = 1'b0; #BUSY_NS ready_busy_n = 1'b1; end join_none
    endtask
    // host wins the wire while it drives; no kindness when released
    assign io_in = !io_oe_n ? io_out : (!ce_n && !read_strobe_n) ? dout : ~dout;
    // command and address latching
    always @(posedge we_n) if (!ce_n) begin
        if (cle && (ready_busy_n || io_out == 8'h70 || io_out == 8'hFF)) begin
            cmd_reg = io_out;
            na = 0;
            case (io_out)
                8'h30: begin ptr = col; mode = 0; go_busy(); end
                8'hE0: ptr = col;
                8'h70: mode = 4;
                8'h00: if (mode == 4) mode = 0;
                8'hEC: begin ptr = 0; mode = 3; end
                8'hFF: begin mode = 5; go_busy(); end
                default: ;
            endcase
        end else if (ale) begin
            if (cmd_reg == 8'h90) begin mode = io_out == 8'h20 ? 2 : 1; ptr = 0; end
            else if (cmd_reg == 8'hEC) go_busy(); // load starts after the address byte
            else if (na == 0) col[7:0] = io_out;
            else if (na == 1) begin col[11:8] = io_out[3:0]; bad = bad | (io_out[7:4] != 0); end
            else if (na == 2) row[7:0] = io_out;
            else if (na == 3) row[15:8] = io_out;
            na++;
        end
    end
    // byte output per read strobe
    always @(negedge read_strobe_n) if (!ce_n) begin
        case (mode)
            0: dout = pg(row, ptr);
            1: dout = 8'hA0 + ptr[7:0]; // arbitrary id bytes
            2: dout = 8'hC0 + ptr[7:0]; // arbitrary signature
            3: dout = ptr[7:0] ^ 8'h3C;
            default: dout = {1'b0, ready_busy_n, ready_busy_n, 5'h00};
        endcase
    end
    always @(posedge read_strobe_n) if (!ce_n && mode != 4) ptr++;
endmodule // flash_dev

/* File: verif/tb_nand_read_host.sv */
// Purpose: self-checking bench for nand_read_host
// Assumes: flash_dev answers on the pins
// Notes: read stream checked against a queue model
`timescale 1ns/10ps
module tb_nand_read_host;
    import nand_host_pkg::*;
    logic ref_clk = 0, reset = 1, req_valid = 0, rd_ready = 0, stall = 0;
    logic [2:0] req_op = 0;
    logic [11:0] req_col = 0, req_count = 0;
    logic [15:0] req_row = 0, row_m = 0;
    logic req_ready, req_done, req_err, rd_valid, ce_n, cle, ale, we_n, read_strobe_n, wp_n, ready_busy_n, io_oe_n, bad;
    logic [7:0] rd_data, io_in, io_out;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, check_count = 0, seed = 32'hfa7a7c28, mode = 0;
    nand_read_host dut(.ref_clk, .reset, .req_valid, .req_ready, .req_op, .req_col, .req_row, .req_count,
        .req_done, .req_err, .rd_valid, .rd_ready, .rd_data, .ce_n, .cle, .ale, .we_n, .read_strobe_n,
        .wp_n, .ready_busy_n, .io_in, .io_out, .io_oe_n);
    flash_dev u_dev(.ce_n, .cle, .ale, .we_n, .read_strobe_n, .io_oe_n, .io_out, .io_in, .ready_busy_n, .bad);
    initial forever #50 ref_clk = ~ref_clk;
    function automatic logic [7:0] pg(logic [15:0] r, logic [11:0] c);
        return r[7:0] ^ r[15:8] ^ c[7:0] ^ {4'h5, c[11:8]};
    endfunction
    task check_byte(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin n_mismatch++; $display("FAIL %0t byte %h not %h", $time, g, e); end
    endtask
    task check_flag(input logic g, input logic e);
        check_count++;
        if (g !== e) begin n_mismatch++; $display("FAIL %0t flag %b not %b", $time, g, e); end
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // drain side, stalls at random
    always @(posedge ref_clk) rd_ready <= #1 !stall && ($random(seed) % 4 != 0);
    always @(posedge ref_clk) if (rd_valid === 1'b1 && rd_ready === 1'b1)
        check_byte(rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    task op(input logic [2:0] o, input logic [11:0] c, input logic [15:0] r, input logic [11:0] n, input logic e);
        int i;
        logic [11:0] k;
        if (!e) begin
            if (o == 0) begin mode = 0; row_m = r; end
            if (o == 3 || o == 4) mode = o;
            if (o == 6) mode = 0;
            if (o == 2) mode = c[7:0] == 8'h20 ? 2 : 1;
            for (i = 0; i < n; i++) begin
                k = (o < 2) ? c + 12'(i) : 12'(i);
                case (mode)
                    0: exp_q.push_back(pg(row_m, k));
                    1: exp_q.push_back(8'hA0 + k[7:0]);
                    2: exp_q.push_back(8'hC0 + k[7:0]);
                    3: exp_q.push_back(k[7:0] ^ 8'h3C);
                    default: exp_q.push_back(8'h60);
                endcase
            end
        end
        req_op = o; req_col = c; req_row = r; req_count = n; req_valid = 1;
        @(posedge ref_clk) while (req_ready !== 1'b1) @(posedge ref_clk);
        #1 req_valid = 0;
        for (i = 0; i < 20000 && req_done !== 1'b1 && req_err !== 1'b1; i++) @(posedge ref_clk) #1;
        check_flag(req_err, e);
        check_flag(req_done, !e);
        for (i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge ref_clk) #1;
        check_flag(exp_q.size() != 0, 1'b0);
        $display("test op %0d col %h done", o, c);
    endtask
    initial begin #5000000; n_mismatch++; results; end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 reset = 0;
        op(1, 12'h000, 0, 4, 1);
        op(7, 12'h000, 0, 1, 1);
        stall = 1;
        fork op(0, 12'h7F0, 16'($random(seed)), 80, 0); begin repeat (80) @(posedge ref_clk); #1 stall = 0; end join
        op(1, 12'h100, 0, 5, 0);
        op(1, 12'h83F, 0, 1, 0);
        op(1, 12'h83F, 0, 2, 1);
        op(2, 12'h000, 0, 5, 0);
        op(2, 12'h020, 0, 4, 0);
        op(3, 12'h000, 0, 520, 0);
        op(1, 12'h1FE, 0, 4, 0);
        op(0, 12'h005, 16'hBEEF, 3, 0);
        op(4, 12'h000, 0, 1, 0);
        op(1, 12'h005, 0, 1, 1);
        op(6, 12'h000, 0, 0, 0);
        op(1, 12'h006, 0, 2, 0);
        op(5, 12'h000, 0, 0, 0);
        op(1, 12'h000, 0, 1, 1);
        check_flag(bad, 1'b0);
        results;
    end
endmodule // tb_nand_read_host
